/* dfm_fault_monitor.v */
// Fault monitor for the converter drive, with its AHB-Lite register file
`timescale 1ns/1ps
`default_nettype none
`include "dfm_map.vh"

module dfm_fault_monitor #(
  parameter integer TICK_CYC      = `DFM_TICK_CYC,
  parameter integer FIELD_OC_TICK = `DFM_FIELD_OC_TICKS
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output reg  [31:0] hrdata,
  output wire        hresp,
  // Drive controller side
  input  wire        enable_pin,
  input  wire        meas_valid,
  input  wire [2:0]  phase_fail,
  input  wire        speed_fb_fault,
  input  wire        sync_fail,
  input  wire [15:0] field_current_meas,
  input  wire [15:0] armature_voltage_meas,
  input  wire [15:0] mains_voltage_meas,
  input  wire [15:0] mains_freq_meas,
  input  wire [15:0] speed_feedback,
  input  wire [1:0]  autotune_select,
  input  wire        autotune_active,
  input  wire        autotune_done,
  input  wire [15:0] inductive_drop_est,
  input  wire [15:0] resistive_drop_est,
  // Trip outputs
  output reg  [9:0]  alarm_flags,
  output reg  [7:0]  alarm_number,
  output reg         drive_locked,
  output reg         field_off_cmd
);

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  reg [`DFM_CTRL_W-1:0] ctrl_r;
  reg [15:0]            rated_field_current_r;
  reg [7:0]             field_boost_pct_r;
  reg [15:0]            rated_mains_voltage_r;
  reg [15:0]            factory_max_r;
  reg [15:0]            mains_alarm_delay_r;
  reg [31:0]            l_range_r;
  reg [31:0]            r_range_r;

  // Bus data-phase state
  reg                   wr_pend_r;
  reg [7:0]             wr_addr_r;
  reg [9:0]             clr_req;

  wire                  addr_ok = hsel & hready & htrans[1];
  assign hreadyout = ce;  // Stall the bus while the block is frozen
  assign hresp     = 1'b0;

  // --------------------------------------------------------------------
  // Enable input synchroniser (three stages, second and third agree)
  // --------------------------------------------------------------------
  reg en_s1_r, en_s2_r, en_s3_r, enable_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_s1_r  <= 1'b0;
      en_s2_r  <= 1'b0;
      en_s3_r  <= 1'b0;
      enable_r <= 1'b0;
    end else if (ce) begin
      en_s1_r <= enable_pin;
      en_s2_r <= en_s1_r;
      en_s3_r <= en_s2_r;
      if (en_s2_r == en_s3_r)
        enable_r <= en_s3_r;
    end
  end

  // --------------------------------------------------------------------
  // Millisecond tick; long counts run on it to keep counters small
  // --------------------------------------------------------------------
  reg [15:0] tick_cnt_r;
  wire       tick = (tick_cnt_r == TICK_CYC[15:0] - 16'h0001);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tick_cnt_r <= 16'h0000;
    else if (ce)
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end

  // --------------------------------------------------------------------
  // Threshold comparisons, captured once per measurement update
  // --------------------------------------------------------------------
  // Operands widened to the product width first, so nothing is cut
  wire [39:0] fld_lhs = {24'h000000, field_current_meas} * 40'h0000002710;
  wire [39:0] fld_rhs = {24'h000000, rated_field_current_r}
                        * {31'h00000000, {1'b0, field_boost_pct_r} + 9'h064}
                        * {32'h00000000, `DFM_FIELD_OC_PCT};
  wire [31:0] arm_lhs = {16'h0000, armature_voltage_meas}
                        * {20'h00000, `DFM_ARM_OV_DEN};
  wire [31:0] arm_rhs = {16'h0000, rated_mains_voltage_r}
                        * {20'h00000, `DFM_ARM_OV_NUM};
  wire [23:0] lim_fmax = {8'h00, factory_max_r} * {16'h0000, `DFM_FMAX_PCT};
  wire [23:0] lim_rat  = {8'h00, rated_mains_voltage_r}
                         * {16'h0000, `DFM_RMAINS_PCT};
  wire [23:0] lim_min  = (lim_fmax < lim_rat) ? lim_fmax : lim_rat;
  wire [23:0] mov_lhs  = {8'h00, mains_voltage_meas}
                         * {16'h0000, `DFM_PCT_BASE};
  wire [15:0] rot_lim  = (autotune_select == `DFM_AT_RESDROP &&
                          ctrl_r[`DFM_CTRL_ENC_WIDE]) ?
                         `DFM_ROT_WIDE : `DFM_ROT_NARROW;

  reg cnd_phase_r, cnd_spd_r, cnd_fld_r, cnd_arm_r;
  reg cnd_freq_r, cnd_sync_r, cnd_rot_r, cnd_mov_r;

  // Registered so each alarm sees one consistent measurement set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnd_phase_r <= 1'b0;
      cnd_spd_r   <= 1'b0;
      cnd_fld_r   <= 1'b0;
      cnd_arm_r   <= 1'b0;
      cnd_freq_r  <= 1'b0;
      cnd_sync_r  <= 1'b0;
      cnd_rot_r   <= 1'b0;
      cnd_mov_r   <= 1'b0;
    end else if (ce && meas_valid) begin
      cnd_phase_r <= |phase_fail;
      cnd_spd_r   <= speed_fb_fault;
      cnd_fld_r   <= fld_lhs > fld_rhs;
      cnd_arm_r   <= arm_lhs > arm_rhs;
      cnd_freq_r  <= (mains_freq_meas > `DFM_FREQ_HI) ||
                     (mains_freq_meas < `DFM_FREQ_LO);
      cnd_sync_r  <= sync_fail;
      cnd_rot_r   <= autotune_active &&
                     ((autotune_select == `DFM_AT_CURRENT &&
                       speed_feedback > `DFM_ROT_NARROW) ||
                      (autotune_select == `DFM_AT_RESDROP &&
                       speed_feedback > rot_lim));
      cnd_mov_r   <= mov_lhs > lim_min;
    end
  end

  // --------------------------------------------------------------------
  // Persistence timers: field overcurrent and mains overvoltage
  // --------------------------------------------------------------------
  reg [15:0] fld_cnt_r;
  reg [15:0] mov_cnt_r;
  wire       fld_run = cnd_fld_r & enable_r;
  wire       mov_run = cnd_mov_r & enable_r;
  wire       fld_due = (fld_cnt_r >= FIELD_OC_TICK[15:0]);
  wire       mov_due = (mov_cnt_r >= mains_alarm_delay_r);

  // Counters restart whenever the condition drops out
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fld_cnt_r <= 16'h0000;
      mov_cnt_r <= 16'h0000;
    end else if (ce) begin
      if (!fld_run)
        fld_cnt_r <= 16'h0000;
      else if (tick && !fld_due)
        fld_cnt_r <= fld_cnt_r + 16'h0001;
      if (!mov_run)
        mov_cnt_r <= 16'h0000;
      else if (tick && !mov_due)
        mov_cnt_r <= mov_cnt_r + 16'h0001;
    end
  end

  // --------------------------------------------------------------------
  // Alarm set terms
  // --------------------------------------------------------------------
  wire [15:0] l_lo = l_range_r[15:0];
  wire [15:0] l_hi = l_range_r[31:16];
  wire [15:0] r_lo = r_range_r[15:0];
  wire [15:0] r_hi = r_range_r[31:16];
  wire [9:0]  set_v;
  wire [9:0]  auto_clr;
  wire        auto_on = ctrl_r[`DFM_CTRL_AUTORST];

  assign set_v[`DFM_ALM_PHASE]   = cnd_phase_r & enable_r &
                                   ~ctrl_r[`DFM_CTRL_PHASE_DIS];
  assign set_v[`DFM_ALM_SPDFB]   = cnd_spd_r &
                                   ~ctrl_r[`DFM_CTRL_SPDFB_DIS];
  assign set_v[`DFM_ALM_FIELDOC] = fld_run & fld_due;
  assign set_v[`DFM_ALM_ARMOV]   = cnd_arm_r &
                                   ~ctrl_r[`DFM_CTRL_ARMOV_DIS];
  assign set_v[`DFM_ALM_LRANGE]  = autotune_done &&
                                   (inductive_drop_est < l_lo ||
                                    inductive_drop_est > l_hi);
  assign set_v[`DFM_ALM_FREQ]    = cnd_freq_r & enable_r;
  assign set_v[`DFM_ALM_SYNC]    = cnd_sync_r & enable_r;
  assign set_v[`DFM_ALM_RRANGE]  = autotune_done &&
                                   (resistive_drop_est < r_lo ||
                                    resistive_drop_est > r_hi);
  assign set_v[`DFM_ALM_ROT]     = cnd_rot_r;
  assign set_v[`DFM_ALM_MOV]     = mov_run & mov_due &
                                   ~ctrl_r[`DFM_CTRL_MOV_DIS];

  // Only the mains micro-break alarms clear themselves
  assign auto_clr = {3'b000,
                     auto_on & ~cnd_sync_r,  1'b0 | (auto_on & ~cnd_freq_r),
                     4'b0000,
                     auto_on & ~cnd_phase_r} &
                    {3'b000, 1'b1, 1'b1, 4'b0000, 1'b1};

  // Lowest-numbered newly set alarm becomes the reported number
  wire [9:0] new_trip = set_v & ~alarm_flags;
  reg  [7:0] new_num;
  reg        found;
  integer    i;

  always @* begin
    new_num = 8'h00;
    found   = 1'b0;
    for (i = 0; i < `DFM_ALM_N; i = i + 1) begin
      if (new_trip[i] && !found) begin
        new_num = `DFM_ALM_FIRST_NUM + i[7:0];
        found   = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Alarm latches, lock and field cut-off; set wins over any clear
  // --------------------------------------------------------------------
  wire [9:0] flags_nxt = (alarm_flags & ~clr_req & ~auto_clr) | set_v;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_flags   <= 10'h000;
      alarm_number  <= 8'h00;
      drive_locked  <= 1'b0;
      field_off_cmd <= 1'b0;
    end else if (ce) begin
      alarm_flags   <= flags_nxt;
      if (found)
        alarm_number <= new_num;
      else if (flags_nxt == 10'h000)
        alarm_number <= 8'h00;
      drive_locked  <= |flags_nxt;
      field_off_cmd <= flags_nxt[`DFM_ALM_FIELDOC];
    end
  end

  // --------------------------------------------------------------------
  // AHB-Lite register access
  // --------------------------------------------------------------------
  wire       wr_now = wr_pend_r;

  // Write-one-to-clear on the status word, in its data phase
  // A cause still present wins, so software cannot hide a live fault
  // Clearing bits that are not set has no effect
  always @* begin
    clr_req = 10'h000;
    if (wr_now && wr_addr_r == `DFM_ADDR_STATUS)
      clr_req = hwdata[9:0];
  end

  // Address capture, configuration writes and registered read data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r             <= 1'b0;
      wr_addr_r             <= 8'h00;
      hrdata                <= 32'h00000000;
      ctrl_r                <= `DFM_RST_CTRL;
      rated_field_current_r <= `DFM_RST_WORD;
      field_boost_pct_r     <= `DFM_RST_BOOST;
      rated_mains_voltage_r <= `DFM_RST_WORD;
      factory_max_r         <= `DFM_RST_WORD;
      mains_alarm_delay_r   <= `DFM_RST_WORD;
      l_range_r             <= `DFM_RST_RANGE;
      r_range_r             <= `DFM_RST_RANGE;
    end else if (ce) begin
      if (hready) begin
        wr_pend_r <= addr_ok & hwrite;
        wr_addr_r <= haddr[7:0];
      end
      if (wr_now) begin
        case (wr_addr_r)
          `DFM_ADDR_CTRL:   ctrl_r <= hwdata[`DFM_CTRL_W-1:0];
          `DFM_ADDR_RFIELD: rated_field_current_r <= hwdata[15:0];
          `DFM_ADDR_BOOST:  field_boost_pct_r <= hwdata[7:0];
          `DFM_ADDR_RMAINS: rated_mains_voltage_r <= hwdata[15:0];
          `DFM_ADDR_FMAX:   factory_max_r <= hwdata[15:0];
          `DFM_ADDR_MDELAY: mains_alarm_delay_r <= hwdata[15:0];
          `DFM_ADDR_LRANGE: l_range_r <= hwdata;
          `DFM_ADDR_RRANGE: r_range_r <= hwdata;
          default:          ctrl_r <= ctrl_r;
        endcase
      end
      if (addr_ok && !hwrite) begin
        case (haddr[7:0])
          `DFM_ADDR_CTRL:   hrdata <= {26'h0000000, ctrl_r};
          `DFM_ADDR_RFIELD: hrdata <= {16'h0000, rated_field_current_r};
          `DFM_ADDR_BOOST:  hrdata <= {24'h000000, field_boost_pct_r};
          `DFM_ADDR_RMAINS: hrdata <= {16'h0000, rated_mains_voltage_r};
          `DFM_ADDR_FMAX:   hrdata <= {16'h0000, factory_max_r};
          `DFM_ADDR_MDELAY: hrdata <= {16'h0000, mains_alarm_delay_r};
          `DFM_ADDR_LRANGE: hrdata <= l_range_r;
          `DFM_ADDR_RRANGE: hrdata <= r_range_r;
          `DFM_ADDR_STATUS: hrdata <= {22'h000000, alarm_flags};
          `DFM_ADDR_ALMNUM: hrdata <= {24'h000000, alarm_number};
          default:          hrdata <= 32'h00000000; // Unmapped reads zero
        endcase
      end
    end
  end

endmodule // dfm_fault_monitor
`default_nettype wire

/* dfm_map.vh */
// Register map, field positions and timing constants of the fault monitor
`ifndef DFM_MAP_VH
`define DFM_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define DFM_ADDR_CTRL      8'h00
`define DFM_ADDR_RFIELD    8'h04
`define DFM_ADDR_BOOST     8'h08
`define DFM_ADDR_RMAINS    8'h0C
`define DFM_ADDR_FMAX      8'h10
`define DFM_ADDR_MDELAY    8'h14
`define DFM_ADDR_LRANGE    8'h18
`define DFM_ADDR_RRANGE    8'h1C
`define DFM_ADDR_STATUS    8'h20
`define DFM_ADDR_ALMNUM    8'h24

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DFM_CTRL_PHASE_DIS 0
`define DFM_CTRL_SPDFB_DIS 1
`define DFM_CTRL_ARMOV_DIS 2
`define DFM_CTRL_MOV_DIS   3
`define DFM_CTRL_AUTORST   4
`define DFM_CTRL_ENC_WIDE  5
`define DFM_CTRL_W         6

// ----------------------------------------------------------------------
// Alarm bit positions in the status word
// ----------------------------------------------------------------------
`define DFM_ALM_PHASE      0
`define DFM_ALM_SPDFB      1
`define DFM_ALM_FIELDOC    2
`define DFM_ALM_ARMOV      3
`define DFM_ALM_LRANGE     4
`define DFM_ALM_FREQ       5
`define DFM_ALM_SYNC       6
`define DFM_ALM_RRANGE     7
`define DFM_ALM_ROT        8
`define DFM_ALM_MOV        9
`define DFM_ALM_N          10
`define DFM_ALM_FIRST_NUM  8'h07

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DFM_RST_CTRL       6'h00
`define DFM_RST_BOOST      8'h00
`define DFM_RST_WORD       16'h0000
`define DFM_RST_RANGE      32'hFFFF0000

// ----------------------------------------------------------------------
// Thresholds (percent, per-mille, 0.1 Hz, 0.1 % of scale)
// ----------------------------------------------------------------------
`define DFM_PCT_BASE       8'd100
`define DFM_FIELD_OC_PCT   8'd115
`define DFM_ARM_OV_NUM     12'd1316
`define DFM_ARM_OV_DEN     12'd1000
`define DFM_FMAX_PCT       8'd110
`define DFM_RMAINS_PCT     8'd120
`define DFM_FREQ_HI        16'd700
`define DFM_FREQ_LO        16'd400
`define DFM_ROT_NARROW     16'd15
`define DFM_ROT_WIDE       16'd100
`define DFM_AT_CURRENT     2'd1
`define DFM_AT_RESDROP     2'd3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DFM_CLK_HZ         10000000
`define DFM_TICK_US        1000
`define DFM_TICK_CYC       ((`DFM_CLK_HZ / 1000000) * `DFM_TICK_US)
`define DFM_FIELD_OC_S     10
`define DFM_FIELD_OC_TICKS (`DFM_FIELD_OC_S * (1000000 / `DFM_TICK_US))

`endif

/* dfm_assertions.sv */
// Port-level checker for the fault monitor
`timescale 1ns/1ps
`default_nettype none
module dfm_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        ce,
  input wire logic        enable_pin,
  input wire logic        meas_valid,
  input wire logic [15:0] mains_freq_meas,
  input wire logic [15:0] speed_feedback,
  input wire logic [1:0]  autotune_select,
  input wire logic        autotune_active,
  input wire logic        autotune_done,
  input wire logic [9:0]  alarm_flags,
  input wire logic [7:0]  alarm_number,
  input wire logic        drive_locked,
  input wire logic        field_off_cmd
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [2:0] en_cnt_r;
  // Enable must outlast the pin synchroniser before it counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) en_cnt_r <= 3'h0;
    else if (!enable_pin) en_cnt_r <= 3'h0;
    else if (en_cnt_r != 3'h7) en_cnt_r <= en_cnt_r + 3'h1;
  end
  // Update steps that must lead to a trip two edges later
  sequence s_freq_bad;
    meas_valid && ce && en_cnt_r == 3'h7 &&
      (mains_freq_meas > 16'h02BC || mains_freq_meas < 16'h0190);
  endsequence
  sequence s_rot_bad;
    meas_valid && ce && autotune_active && autotune_select == 2'h1 &&
      speed_feedback > 16'h000F;
  endsequence
  property p_freq;
    s_freq_bad |-> ##2 alarm_flags[5];
  endproperty
  // Once the enable has long settled, only a fresh update can raise it
  property p_freq_upd;
    $rose(alarm_flags[5]) && $past(en_cnt_r, 2) == 3'h7 |->
      $past(meas_valid, 2);
  endproperty
  property p_rot;
    s_rot_bad |-> ##2 alarm_flags[8];
  endproperty
  property p_lrange;
    $rose(alarm_flags[4]) |-> $past(autotune_done);
  endproperty
  property p_rrange;
    $rose(alarm_flags[7]) |-> $past(autotune_done);
  endproperty
  // Output flops load from the same next value as the flags
  property p_lock;
    drive_locked == (|alarm_flags);
  endproperty
  property p_foff;
    field_off_cmd == alarm_flags[2];
  endproperty
  property p_num0;
    alarm_flags == 10'h000 && $past(alarm_flags) == 10'h000 |->
      alarm_number == 8'h00;
  endproperty
  a_freq: assert property (p_freq)
    else $error("frequency alarm missing");
  a_freq_upd: assert property (p_freq_upd)
    else $error("frequency alarm without update");
  a_rot: assert property (p_rot)
    else $error("rotation alarm missing");
  a_lrange: assert property (p_lrange)
    else $error("inductance alarm without autotune end");
  a_rrange: assert property (p_rrange)
    else $error("resistance alarm without autotune end");
  a_lock: assert property (p_lock)
    else $error("lock does not follow flags");
  a_foff: assert property (p_foff)
    else $error("field off does not follow flag");
  a_num0: assert property (p_num0)
    else $error("alarm number not zero while clear");
endmodule // dfm_assertions
`default_nettype wire

/* dfm_drive_model.sv */
// Drive controller model: paced updates and autotune end strobe
`timescale 1ns/1ps
`default_nettype none
module dfm_drive_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic done_req,
  output var  logic meas_valid,
  output var  logic autotune_done
);
  logic [2:0] cnt_r;
  // One strobe every 8 clocks keeps each result apart from the next
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 3'h0;
      meas_valid <= 1'b0;
      autotune_done <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      meas_valid <= (cnt_r == 3'h7);
      autotune_done <= done_req;
    end
  end
endmodule // dfm_drive_model
`default_nettype wire

/* dfm_fault_monitor_bench.sv */
// Self-checking bench for the fault monitor
`timescale 1ns/1ps
`default_nettype none
module dfm_fault_monitor_bench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        en = 1'b0;
  logic        done_req = 1'b0;
  logic [2:0]  ph = 3'h0;
  logic        spd_f = 1'b0;
  logic        syn_f = 1'b0;
  logic [15:0] fld = 16'h0, arm = 16'h0, mv = 16'h0, frq = 16'h01F4;
  logic [15:0] spd = 16'h0, l_est = 16'h0, r_est = 16'h0;
  logic [1:0]  sel = 2'h0;
  logic        act = 1'b0;
  wire         rdy, hresp, mval, adone, locked, foff;
  wire  [31:0] hrdata;
  wire  [9:0]  flags;
  wire  [7:0]  anum;
  logic [31:0] rd;
  int          num_errors = 0;
  int          n_checks = 0;

  always #50 hclk = ~hclk;

  dfm_fault_monitor #(.TICK_CYC(10), .FIELD_OC_TICK(5)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(rdy), .hreadyout(rdy), .hrdata(hrdata),
    .hresp(hresp), .enable_pin(en), .meas_valid(mval),
    .phase_fail(ph), .speed_fb_fault(spd_f), .sync_fail(syn_f),
    .field_current_meas(fld), .armature_voltage_meas(arm),
    .mains_voltage_meas(mv), .mains_freq_meas(frq),
    .speed_feedback(spd), .autotune_select(sel),
    .autotune_active(act), .autotune_done(adone),
    .inductive_drop_est(l_est), .resistive_drop_est(r_est),
    .alarm_flags(flags), .alarm_number(anum), .drive_locked(locked),
    .field_off_cmd(foff));
  dfm_drive_model u_ctl (.hclk(hclk), .hresetn(hresetn),
    .done_req(done_req), .meas_valid(mval), .autotune_done(adone));

  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single word transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (rdy !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (rdy !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  // Let the cause settle, clear all flags, wait, then look at one
  task automatic chk(input int b, input logic e, input int n);
    repeat (n) @(posedge hclk);
    ahb(1'b1, 8'h20, 32'h000003FF);
    repeat (n) @(posedge hclk);
    ahb(1'b0, 8'h20, 32'h0);
    cmp({31'h0, rd[b]}, {31'h0, e});
  endtask

  // Watchdog well beyond the few thousand cycles the run needs
  initial begin
    #(20000 * 100);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0);
    cmp(rd, 32'h0);
    ahb(1'b0, 8'h18, 32'h0);
    cmp(rd, 32'hFFFF0000);
    ahb(1'b0, 8'h40, 32'h0);
    cmp(rd, 32'h0);
    cmp({31'h0, hresp}, 32'h0);
    frq <= 16'h0320;
    chk(5, 1'b0, 30);
    en <= 1'b1;
    chk(5, 1'b1, 30);
    cmp({24'h0, anum}, 32'h0C);
    cmp({31'h0, locked}, 32'h1);
    // Both edges of the legal band, 40.0 and 70.0 Hz
    for (int i = 0; i < 4; i++) begin
      frq <= (i == 0) ? 16'h02BD : (i == 1) ? 16'h02BC :
             (i == 2) ? 16'h0190 : 16'h018F;
      chk(5, (i == 0 || i == 3), 30);
    end
    ahb(1'b1, 8'h00, 32'h10);
    frq <= 16'h0320;
    chk(5, 1'b1, 30);
    frq <= 16'h01F4;
    repeat (30) @(posedge hclk);
    ahb(1'b0, 8'h20, 32'h0);
    cmp(rd & 32'h20, 32'h0);
    ahb(1'b1, 8'h00, 32'h0);
    ph <= 3'h2;
    chk(0, 1'b1, 30);
    ahb(1'b1, 8'h00, 32'h1);
    chk(0, 1'b0, 30);
    ph <= 3'h0;
    spd_f <= 1'b1;
    chk(1, 1'b1, 30);
    ahb(1'b1, 8'h00, 32'h2);
    chk(1, 1'b0, 30);
    spd_f <= 1'b0;
    syn_f <= 1'b1;
    chk(6, 1'b1, 30);
    syn_f <= 1'b0;
    ahb(1'b1, 8'h0C, 32'h0190);
    ahb(1'b1, 8'h10, 32'h01F4);
    arm <= 16'h020E;
    chk(3, 1'b0, 30);
    arm <= 16'h020F;
    chk(3, 1'b1, 30);
    ahb(1'b1, 8'h00, 32'h4);
    chk(3, 1'b0, 30);
    arm <= 16'h0;
    mv <= 16'h01E0;
    chk(9, 1'b0, 30);
    mv <= 16'h01E1;
    chk(9, 1'b1, 30);
    ahb(1'b1, 8'h00, 32'h8);
    chk(9, 1'b0, 30);
    mv <= 16'h0;
    ahb(1'b1, 8'h14, 32'h8);
    ahb(1'b1, 8'h00, 32'h0);
    mv <= 16'h01E1;
    chk(9, 1'b0, 10);
    // Update phase plus eight tick periods can take close to 90 cycles
    repeat (75) @(posedge hclk);
    ahb(1'b0, 8'h20, 32'h0);
    cmp(rd & 32'h200, 32'h200);
    mv <= 16'h0;
    ahb(1'b1, 8'h04, 32'h0064);
    fld <= 16'h0073;
    chk(2, 1'b0, 70);
    fld <= 16'h0074;
    chk(2, 1'b1, 70);
    cmp({31'h0, foff}, 32'h1);
    ahb(1'b1, 8'h08, 32'h14);
    fld <= 16'h008A;
    chk(2, 1'b0, 70);
    fld <= 16'h008B;
    chk(2, 1'b1, 70);
    en <= 1'b0;
    chk(2, 1'b0, 70);
    fld <= 16'h0;
    act <= 1'b1;
    sel <= 2'h1;
    spd <= 16'h000F;
    chk(8, 1'b0, 30);
    spd <= 16'h0010;
    chk(8, 1'b1, 30);
    sel <= 2'h3;
    chk(8, 1'b1, 30);
    ahb(1'b1, 8'h00, 32'h20);
    spd <= 16'h0064;
    chk(8, 1'b0, 30);
    spd <= 16'h0065;
    chk(8, 1'b1, 30);
    act <= 1'b0;
    sel <= 2'h1;
    ahb(1'b1, 8'h18, 32'h00C80064);
    ahb(1'b1, 8'h1C, 32'h00C80064);
    // Inductance too high first, then resistance too low
    for (int i = 0; i < 2; i++) begin
      l_est <= i ? 16'h0096 : 16'h00FA;
      r_est <= i ? 16'h0032 : 16'h0096;
      ahb(1'b1, 8'h20, 32'h000003FF);
      done_req <= 1'b1;
      @(posedge hclk);
      done_req <= 1'b0;
      repeat (4) @(posedge hclk);
      ahb(1'b0, 8'h20, 32'h0);
      cmp(rd & 32'h90, i ? 32'h80 : 32'h10);
    end
    close_out();
  end
endmodule // dfm_fault_monitor_bench

bind dfm_fault_monitor dfm_assertions u_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .enable_pin(enable_pin),
  .meas_valid(meas_valid), .mains_freq_meas(mains_freq_meas),
  .speed_feedback(speed_feedback), .autotune_select(autotune_select),
  .autotune_active(autotune_active), .autotune_done(autotune_done),
  .alarm_flags(alarm_flags), .alarm_number(alarm_number),
  .drive_locked(drive_locked), .field_off_cmd(field_off_cmd));
`default_nettype wire
